// >>> csm_clock_monitor.v
// Purpose: system clock group select, fail-safe monitor, power-up reset sequencing
// Assumes: oscillator clocks arrive on pins well below ref_clk/2
// Notes: analog oscillators sit outside; this block only enables and supervises them
`timescale 1ns/1ps
`include "csm_defs.vh"

// Behaviour
// - secondary 32k oscillator stays on, even in sleep, while keep-on bit is set
// - secondary group runs the system only when selected and keep-on is set
// - multiplier gains x4, x8, x16; x16 only for inputs up to 7.5 MHz
// - multiplier lock follows the loop and reads back as a status bit
// - fast RC runs the system whenever current group equals 01, except in sleep
// - four-bit signed fast RC trim, 0000 calibrated, 0111 highest, 1000 lowest
// - slow RC on at power-on, stopped after power-up delay unless still needed
// - switch_monitor_cfg 1x disables switching and monitor, the default
// - with monitor enabled slow RC runs except in sleep, whatever soft watchdog says
// - on clock failure: trap, current group to fast RC, set fail flag, clear request
// - clock failure leaves watchdog counting from slow RC
// - oscillator not started at power-up delay expiry traps to fast RC
// - switching moves only between groups; primary option from primary_mode_cfg
// - current group read-only; requested writable; both load boot_group_cfg at power-on
// - request 0 to 1 starts a switch; clearing it aborts one in progress
// - switching disabled: config bits select directly, current group only reflects it
// - low byte writable only right after key writes 0x46 then 0x57
// - high byte writable only right after key writes 0x78 then 0x9A
// - reset causes told apart and kept in software-readable status bits
// - master clear input filtered; internal resets never drive that pin
// - bias delay plus 0/4/16/64 ms, then release reset on quarter-phase edge
// - crystal modes gate the clock until 1024 oscillator cycles counted
module csm_clock_monitor #(
	parameter [23:0] POWER_UP_UNIT_CYCLES = 24'h00C350
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// configuration bits
	input wire [1:0] switchMonitorCfg,
	input wire [1:0] bootGroupCfg,
	input wire [3:0] primaryModeCfg,
	input wire [1:0] powerUpDelayCfg,
	input wire watchdogCfgEnable,
	input wire softWatchdogEnable,
	// core events, same clock
	input wire sleepMode,
	input wire idleMode,
	input wire wdtTimeout,
	input wire resetInstr,
	input wire trapLockup,
	input wire illegalOp,
	// pins and analog detectors
	input wire masterClearPinN,
	input wire brownOutDetect,
	input wire primaryOscClk,
	input wire secondaryOscClk,
	input wire pllLockIn,
	// oscillator controls
	output wire primaryOscEnable,
	output wire secondaryOscEnable,
	output wire fastRcEnable,
	output wire slowRcEnable,
	output wire [1:0] pllMultSel,
	output wire [3:0] fastRcTrim,
	output wire [1:0] sysClkGroup,
	output wire sysClkRun,
	// reset and trap
	output wire internalSystemReset,
	output wire firstQuarterPhase,
	output wire clockFailTrap
);

// ****************************************
// local codes
// ****************************************
localparam [2:0] PS_BIAS = 3'h0;
localparam [2:0] PS_POWER_UP_DELAY_TIMER = 3'h1;
localparam [2:0] PS_Q1 = 3'h2;
localparam [2:0] PS_RUN = 3'h3;
localparam [2:0] PS_HOLD = 3'h4;
localparam [1:0] UL_IDLE = 2'h0;
localparam [1:0] UL_FIRST = 2'h1;
localparam [1:0] UL_OPEN = 2'h2;
localparam [23:0] UNIT_LAST = POWER_UP_UNIT_CYCLES - 24'h000001;
localparam [31:0] BIAS_CYC = `CSM_BIAS_CYC;
localparam [31:0] FAIL_CYC = `CSM_FAIL_CYC;
localparam [31:0] MASTER_CLEAR_PIN_CYC = `CSM_MASTER_CLEAR_PIN_CYC;
localparam [23:0] BIAS_LAST = BIAS_CYC[23:0] - 24'h000001;
localparam [9:0] FAIL_LAST = FAIL_CYC[9:0] - 10'h001;
localparam [3:0] MASTER_CLEAR_PIN_LAST = MASTER_CLEAR_PIN_CYC[3:0] - 4'h1;

// ****************************************
// functions
// ****************************************
// gain decode
function [1:0] pllMult;
	input [3:0] mode;
	begin
		case (mode)
			4'h5, 4'hD, 4'h1: pllMult = 2'h1;
			4'h6, 4'hE, 4'hA: pllMult = 2'h2;
			4'h7, 4'hF, 4'h3: pllMult = 2'h3;
			default: pllMult = 2'h0;
		endcase
	end
endfunction

function isCrystal;
	input [3:0] mode;
	begin
		isCrystal = (mode == 4'h0) || (mode == 4'h2) || (mode[3:2] == 2'h1);
	end
endfunction

function [6:0] pwrtMs;
	input [1:0] sel;
	begin
		case (sel)
			2'h0: pwrtMs = `CSM_POWER_UP_DELAY_TIMER_MS0;
			2'h1: pwrtMs = `CSM_POWER_UP_DELAY_TIMER_MS1;
			2'h2: pwrtMs = `CSM_POWER_UP_DELAY_TIMER_MS2;
			default: pwrtMs = `CSM_POWER_UP_DELAY_TIMER_MS3;
		endcase
	end
endfunction

// two-key unlock step; any other transfer drops it
function [1:0] unlockNext;
	input [1:0] st;
	input xfer;
	input hit;
	input [7:0] d;
	input [7:0] k1;
	input [7:0] k2;
	begin
		if (!xfer)
			unlockNext = st;
		else if (!hit)
			unlockNext = UL_IDLE;
		else
			case (st)
				UL_IDLE: unlockNext = (d == k1) ? UL_FIRST : UL_IDLE;
				UL_FIRST: unlockNext = (d == k2) ? UL_OPEN : ((d == k1) ? UL_FIRST : UL_IDLE);
				default: unlockNext = UL_IDLE;
			endcase
	end
endfunction

// ****************************************
// declarations
// ****************************************
reg [4:0] syncA_reg;
reg [4:0] syncB_reg;
reg [2:0] oscLast_reg;
reg [3:0] mclrCnt_reg;
reg mclrLow_reg;
reg mclrLowLast_reg;
reg [1:0] phase_reg;
reg fqp_reg;
reg [2:0] pwrState_reg;
reg [23:0] delay_reg;
reg [6:0] ms_reg;
reg [1:0] cosc_reg;
reg [1:0] nosc_reg;
reg switch_request_reg;
reg keep32k_reg;
reg cf_reg;
reg trap_reg;
reg [9:0] ost_reg;
reg ostDone_reg;
reg [9:0] failCnt_reg;
reg [1:0] unlockLo_reg;
reg [1:0] unlockHi_reg;
reg [3:0] trim_reg;
reg [8:0] cause_reg;
reg [31:0] prdata_reg;
reg pslverr_reg;
reg priEn_reg;
reg secEn_reg;
reg frcEn_reg;
reg slowEn_reg;
reg [1:0] mult_reg;
reg [1:0] grp_reg;
reg run_reg;

wire mclrSyncN = syncB_reg[0];
wire borSync = syncB_reg[1];
wire priSync = syncB_reg[2];
wire secSync = syncB_reg[3];
wire lockSync = syncB_reg[4];
wire priEdge = priSync & ~oscLast_reg[0];
wire secEdge = secSync & ~oscLast_reg[1];
wire borRise = borSync & ~oscLast_reg[2];
wire q1Tick = (phase_reg == `CSM_QDIV);
wire xfer = psel & penable;
wire wrOsc = xfer & pwrite & (paddr == `CSM_OFF_OSC);
wire wLo = wrOsc & pstrb[0] & (unlockLo_reg == UL_OPEN);
wire wHi = wrOsc & pstrb[1] & (unlockHi_reg == UL_OPEN);
wire monitorEn = (switchMonitorCfg == 2'h0);
wire switchEn = ~switchMonitorCfg[1];
wire wdtOn = watchdogCfgEnable | softWatchdogEnable;
wire [1:0] startGrp = switch_request_reg ? nosc_reg : cosc_reg;
wire grpEdge = (startGrp == `CSM_GRP_SEC) ? secEdge : priEdge;
wire ostNeed = (startGrp == `CSM_GRP_SEC) ||
	((startGrp == `CSM_GRP_PRI) && isCrystal(primaryModeCfg));
wire pllUsed = (pllMult(primaryModeCfg) != 2'h0);
wire startReady;
wire pwrtDone = (pwrState_reg == PS_POWER_UP_DELAY_TIMER) && (ms_reg == pwrtMs(powerUpDelayCfg));
wire extGrp = (cosc_reg == `CSM_GRP_PRI) || (cosc_reg == `CSM_GRP_SEC);
wire swStart = wLo & pwdata[`CSM_B_SWREQ] & ~switch_request_reg;
wire watchOn;
wire clockFail;

// secondary counts as ready only with keep-on
// crystal readiness waits on settle count
assign startReady = (startGrp == `CSM_GRP_SEC) ? (ostDone_reg & keep32k_reg) :
	(startGrp == `CSM_GRP_PRI) ? ((~ostNeed | ostDone_reg) & (~pllUsed | lockSync)) :
	1'b1;
assign watchOn = monitorEn & (pwrState_reg == PS_RUN) & ~sleepMode & ~switch_request_reg & extGrp;
// not started when power-up delay runs out
assign clockFail = (watchOn & (failCnt_reg == FAIL_LAST)) |
	(monitorEn & pwrtDone & extGrp & ~startReady);

// ****************************************
// pin synchronisers and filter
// ****************************************
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		syncA_reg <= 5'h01;
		syncB_reg <= 5'h01;
		oscLast_reg <= 3'h0;
		mclrCnt_reg <= 4'h0;
		mclrLow_reg <= 1'b0;
		mclrLowLast_reg <= 1'b0;
	end
	else
	begin
		syncA_reg <= {pllLockIn, secondaryOscClk, primaryOscClk, brownOutDetect, masterClearPinN};
		syncB_reg <= syncA_reg;
		oscLast_reg <= {borSync, secSync, priSync};
		mclrLowLast_reg <= mclrLow_reg;
		// short low pulses never reach the reset
		if (mclrSyncN)
		begin
			mclrCnt_reg <= 4'h0;
			mclrLow_reg <= 1'b0;
		end
		else if (mclrCnt_reg == MASTER_CLEAR_PIN_LAST)
			mclrLow_reg <= 1'b1;
		else
			mclrCnt_reg <= mclrCnt_reg + 4'h1;
	end
end

// ****************************************
// power-up and reset sequencing
// ****************************************
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		pwrState_reg <= PS_BIAS;
		delay_reg <= 24'h000000;
		ms_reg <= 7'h00;
		phase_reg <= 2'h0;
		fqp_reg <= 1'b0;
	end
	else
	begin
		phase_reg <= phase_reg + 2'h1;
		fqp_reg <= q1Tick;
		if (borRise)
		begin
			pwrState_reg <= PS_BIAS;
			delay_reg <= 24'h000000;
		end
		else
			case (pwrState_reg)
				PS_BIAS:
				begin
					if (delay_reg == BIAS_LAST)
					begin
						pwrState_reg <= PS_POWER_UP_DELAY_TIMER;
						delay_reg <= 24'h000000;
						ms_reg <= 7'h00;
					end
					else
						delay_reg <= delay_reg + 24'h000001;
				end
				PS_POWER_UP_DELAY_TIMER:
				begin
					if (pwrtDone)
						pwrState_reg <= PS_Q1;
					else if (delay_reg == UNIT_LAST)
					begin
						delay_reg <= 24'h000000;
						ms_reg <= ms_reg + 7'h01;
					end
					else
						delay_reg <= delay_reg + 24'h000001;
				end
				PS_Q1:
				begin
					if (mclrLow_reg)
						pwrState_reg <= PS_HOLD;
					else if (q1Tick)
						pwrState_reg <= PS_RUN;
				end
				PS_RUN:
				begin
					if (mclrLow_reg)
						pwrState_reg <= PS_HOLD;
					else if (wdtTimeout | resetInstr | trapLockup | illegalOp)
						pwrState_reg <= PS_Q1;
				end
				PS_HOLD:
				begin
					if (!mclrLow_reg)
						pwrState_reg <= PS_Q1;
				end
				default: pwrState_reg <= PS_BIAS;
			endcase
	end
end

// ****************************************
// clock group control
// ****************************************
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		cosc_reg <= `CSM_GRP_FRC;
		nosc_reg <= `CSM_GRP_FRC;
		switch_request_reg <= 1'b0;
		keep32k_reg <= 1'b0;
		cf_reg <= 1'b0;
		trap_reg <= 1'b0;
	end
	else
	begin
		trap_reg <= 1'b0;
		if (wLo)
			keep32k_reg <= pwdata[`CSM_B_KEEP32K];
		// requested group writable behind the high-byte lock
		if (wHi)
			nosc_reg <= pwdata[`CSM_NOSC_HI:`CSM_NOSC_LO];
		if ((pwrState_reg == PS_BIAS) || borRise)
		begin
			// both groups load from boot config
			cosc_reg <= bootGroupCfg;
			nosc_reg <= bootGroupCfg;
			switch_request_reg <= 1'b0;
		end
		else if (clockFail)
		begin
			// fall back to fast RC and flag it
			cosc_reg <= `CSM_GRP_FRC;
			cf_reg <= 1'b1;
			switch_request_reg <= 1'b0;
			trap_reg <= 1'b1;
		end
		else if (!switchEn)
		begin
			cosc_reg <= bootGroupCfg;
			switch_request_reg <= 1'b0;
		end
		else if (wLo && !pwdata[`CSM_B_SWREQ])
			switch_request_reg <= 1'b0;
		else if (switch_request_reg && startReady)
		begin
			// whole group moves; primary option stays config driven
			cosc_reg <= nosc_reg;
			switch_request_reg <= 1'b0;
		end
		else if (swStart)
			switch_request_reg <= 1'b1;
	end
end

// ****************************************
// settle timer and failure watch
// ****************************************
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		ost_reg <= 10'h000;
		ostDone_reg <= 1'b0;
		failCnt_reg <= 10'h000;
	end
	else
	begin
		// restart on power-up, sleep and each new switch
		if ((pwrState_reg == PS_BIAS) || sleepMode || swStart)
		begin
			ost_reg <= 10'h000;
			ostDone_reg <= 1'b0;
		end
		else if (!ostDone_reg && grpEdge)
		begin
			ost_reg <= ost_reg + 10'h001;
			if (ost_reg == `CSM_OST_LAST)
				ostDone_reg <= 1'b1;
		end
		// no edge for a full window means lost clock
		if (!watchOn || grpEdge || clockFail)
			failCnt_reg <= 10'h000;
		else
			failCnt_reg <= failCnt_reg + 10'h001;
	end
end

// ****************************************
// register bus
// ****************************************
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		unlockLo_reg <= UL_IDLE;
		unlockHi_reg <= UL_IDLE;
		trim_reg <= 4'h0;
		cause_reg <= `CSM_RC_RESET;
		prdata_reg <= 32'h00000000;
		pslverr_reg <= 1'b0;
	end
	else
	begin
		unlockLo_reg <= unlockNext(unlockLo_reg, xfer, wrOsc & pstrb[0], pwdata[7:0],
			`CSM_KEY_LO1, `CSM_KEY_LO2);
		unlockHi_reg <= unlockNext(unlockHi_reg, xfer, wrOsc & pstrb[1], pwdata[15:8],
			`CSM_KEY_HI1, `CSM_KEY_HI2);
		if (xfer && pwrite && (paddr == `CSM_OFF_TRIM) && pstrb[0])
			trim_reg <= pwdata[3:0];
		// causes set, software clears by writing ones; set wins
		cause_reg <= (cause_reg & ~(((xfer && pwrite && (paddr == `CSM_OFF_CAUSE)) ?
			{pstrb[1], {8{pstrb[0]}}} : 9'h000) & pwdata[8:0])) |
			({trapLockup, illegalOp, mclrLow_reg & ~mclrLowLast_reg, resetInstr,
			wdtTimeout, sleepMode & (wdtTimeout | mclrLow_reg),
			idleMode & mclrLow_reg, borRise, 1'b0});
		if (psel && !penable)
		begin
			pslverr_reg <= 1'b0;
			case (paddr)
				`CSM_OFF_OSC: prdata_reg <= {18'h00000, cosc_reg, 2'h0, nosc_reg, 2'h0,
					lockSync, 1'b0, cf_reg, 1'b0, keep32k_reg, switch_request_reg};
				`CSM_OFF_TRIM: prdata_reg <= {28'h0000000, trim_reg};
				`CSM_OFF_CAUSE: prdata_reg <= {23'h000000, cause_reg};
				`CSM_OFF_STAT: prdata_reg <= {21'h000000, pwrState_reg, ostDone_reg,
					switchMonitorCfg, mult_reg, slowEn_reg, 1'b0, run_reg};
				default:
				begin
					prdata_reg <= 32'h00000000;
					pslverr_reg <= 1'b1;
				end
			endcase
		end
	end
end

// ****************************************
// oscillator enables
// ****************************************
always @(posedge ref_clk)
begin
	if (!rst_n)
	begin
		priEn_reg <= 1'b0;
		secEn_reg <= 1'b0;
		frcEn_reg <= 1'b0;
		slowEn_reg <= 1'b1;
		mult_reg <= 2'h0;
		grp_reg <= `CSM_GRP_FRC;
		run_reg <= 1'b0;
	end
	else
	begin
		priEn_reg <= ~sleepMode & ((cosc_reg == `CSM_GRP_PRI) |
			(switch_request_reg & (nosc_reg == `CSM_GRP_PRI)));
		secEn_reg <= keep32k_reg | (~sleepMode & ((cosc_reg == `CSM_GRP_SEC) |
			(switch_request_reg & (nosc_reg == `CSM_GRP_SEC))));
		// fast RC runs for its group
		frcEn_reg <= ~sleepMode & ((cosc_reg == `CSM_GRP_FRC) |
			(switch_request_reg & (nosc_reg == `CSM_GRP_FRC)) |
			((cosc_reg == `CSM_GRP_PRI) & ~isCrystal(primaryModeCfg) & pllUsed &
			(primaryModeCfg[3:2] != 2'h3)));
		// on until power-up delay, then only when needed
		// monitor keeps it running outside sleep
		// watchdog keeps its clock through a failure
		slowEn_reg <= (pwrState_reg == PS_BIAS) | (pwrState_reg == PS_POWER_UP_DELAY_TIMER) |
			(monitorEn & ~sleepMode) | wdtOn |
			((cosc_reg == `CSM_GRP_SLOW) & ~sleepMode);
		// gain applies to primary group only
		mult_reg <= (cosc_reg == `CSM_GRP_PRI) ? pllMult(primaryModeCfg) : 2'h0;
		grp_reg <= cosc_reg;
		// current clock keeps running while a switch is pending
		run_reg <= switch_request_reg | ((cosc_reg == startGrp) & startReady);
	end
end

// ****************************************
// outputs
// ****************************************
// zero wait states keep the host simple
assign pready = psel & penable;
assign prdata = prdata_reg;
assign pslverr = pslverr_reg;
assign primaryOscEnable = priEn_reg;
assign secondaryOscEnable = secEn_reg;
assign fastRcEnable = frcEn_reg;
assign slowRcEnable = slowEn_reg;
assign pllMultSel = mult_reg;
assign fastRcTrim = trim_reg;
assign sysClkGroup = grp_reg;
assign sysClkRun = run_reg;
assign internalSystemReset = (pwrState_reg != PS_RUN);
assign firstQuarterPhase = fqp_reg;
assign clockFailTrap = trap_reg;

endmodule

// >>> csm_defs.vh
// Purpose: shared constants of the clock select and fail-safe monitor
// Assumes: 50 MHz ref_clk, 32-bit APB register bus
// Notes: header only, no logic
`ifndef CSM_DEFS_VH
`define CSM_DEFS_VH

// ****************************************
// register map
// ****************************************
`define CSM_OFF_OSC 12'h000
`define CSM_OFF_TRIM 12'h004
`define CSM_OFF_CAUSE 12'h008
`define CSM_OFF_STAT 12'h00C

// ****************************************
// oscillator_control fields
// ****************************************
`define CSM_B_SWREQ 0
`define CSM_B_KEEP32K 1
`define CSM_B_CF 3
`define CSM_B_LOCK 5
`define CSM_NOSC_LO 8
`define CSM_NOSC_HI 9
`define CSM_COSC_LO 12
`define CSM_COSC_HI 13

// ****************************************
// clock groups and unlock keys
// ****************************************
`define CSM_GRP_SEC 2'h0
`define CSM_GRP_FRC 2'h1
`define CSM_GRP_SLOW 2'h2
`define CSM_GRP_PRI 2'h3
`define CSM_KEY_LO1 8'h46
`define CSM_KEY_LO2 8'h57
`define CSM_KEY_HI1 8'h78
`define CSM_KEY_HI2 8'h9A

// ****************************************
// reset cause bits
// ****************************************
`define CSM_RC_POR 0
`define CSM_RC_BOR 1
`define CSM_RC_IDLE 2
`define CSM_RC_SLEEP 3
`define CSM_RC_WDTO 4
`define CSM_RC_SWR 5
`define CSM_RC_EXTR 6
`define CSM_RC_IOP 7
`define CSM_RC_TRAP 8
`define CSM_RC_RESET 9'h003

// ****************************************
// timing
// ****************************************
`define CSM_CLK_MHZ 50
`define CSM_BIAS_NS 10000
`define CSM_BIAS_CYC ((`CSM_BIAS_NS * `CSM_CLK_MHZ) / 1000)
`define CSM_FAIL_NS 10000
`define CSM_FAIL_CYC ((`CSM_FAIL_NS * `CSM_CLK_MHZ) / 1000)
`define CSM_MASTER_CLEAR_PIN_NS 200
`define CSM_MASTER_CLEAR_PIN_CYC ((`CSM_MASTER_CLEAR_PIN_NS * `CSM_CLK_MHZ) / 1000)
`define CSM_POWER_UP_DELAY_TIMER_MS0 7'h00
`define CSM_POWER_UP_DELAY_TIMER_MS1 7'h04
`define CSM_POWER_UP_DELAY_TIMER_MS2 7'h10
`define CSM_POWER_UP_DELAY_TIMER_MS3 7'h40
`define CSM_OST_LAST 10'h3FF
`define CSM_QDIV 2'h3
`endif

// >>> csm_osc_model.sv
// Purpose: behavioural crystal, 32 kHz oscillator and multiplier lock
// Assumes: enables come from the clock monitor
// Notes: both clocks sped up so settle counts stay short
`timescale 1ns/1ps
module csm_osc_model (
	// controls
	input wire primaryOscEnable,
	input wire secondaryOscEnable,
	input wire priRun,
	// oscillator side
	output logic primaryOscClk,
	output logic secondaryOscClk,
	output logic pllLockIn
);
	// input under 7.5 MHz for x16
	initial
	begin
		primaryOscClk = 1'b0;
		forever #70 if (primaryOscEnable && priRun) primaryOscClk = ~primaryOscClk;
	end

	initial
	begin
		secondaryOscClk = 1'b0;
		forever #100 if (secondaryOscEnable) secondaryOscClk = ~secondaryOscClk;
	end

	// lock drops with the clock, no memory
	assign pllLockIn = primaryOscEnable && priRun;
endmodule

// >>> csm_clock_monitor_properties.sv
// Purpose: port checks for the clock monitor
// Assumes: one ref_clk domain, rst_n synchronous active low
// Notes: config inputs change only under reset
`timescale 1ns/1ps
module csm_clock_monitor_properties (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// apb
	input wire psel,
	input wire penable,
	input wire [11:0] paddr,
	input wire pready,
	input wire pslverr,
	// configuration
	input wire [1:0] switchMonitorCfg,
	input wire [1:0] bootGroupCfg,
	input wire sleepMode,
	input wire watchdogCfgEnable,
	input wire softWatchdogEnable,
	// outputs
	input wire slowRcEnable,
	input wire [1:0] sysClkGroup,
	input wire internalSystemReset,
	input wire firstQuarterPhase,
	input wire clockFailTrap
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	apb_no_wait_a: assert property (psel && penable |-> pready)
		else $error("pready low in access cycle");
	unmapped_err_a: assert property (psel && penable && paddr > 12'h00C |-> pslverr)
		else $error("no error on unmapped address");
	trap_pulse_a: assert property (clockFailTrap |=> !clockFailTrap)
		else $error("trap longer than one cycle");
	trap_group_a: assert property (clockFailTrap |-> ##[0:1] sysClkGroup == 2'h1)
		else $error("trap without fast rc group");
	monitor_off_a: assert property (switchMonitorCfg[1] |-> !clockFailTrap)
		else $error("trap while monitor disabled");
	direct_select_a: assert property (switchMonitorCfg[1] && !internalSystemReset
		|-> sysClkGroup == bootGroupCfg)
		else $error("group differs from boot config");
	quarter_tick_a: assert property (firstQuarterPhase
		|=> !firstQuarterPhase [*3] ##1 firstQuarterPhase)
		else $error("quarter tick not every fourth cycle");
	reset_release_a: assert property ($fell(internalSystemReset)
		|-> firstQuarterPhase || $past(firstQuarterPhase))
		else $error("reset released off quarter tick");
	slow_rc_keep_a: assert property ((switchMonitorCfg == 2'h0 && !sleepMode) [*2]
		|-> slowRcEnable)
		else $error("slow rc off with monitor on");
	slow_rc_stop_a: assert property ($fell(slowRcEnable) |-> !watchdogCfgEnable
		&& !softWatchdogEnable && sysClkGroup != 2'h2)
		else $error("slow rc stopped while needed");
endmodule

bind csm_clock_monitor csm_clock_monitor_properties chk_u (
	.ref_clk(ref_clk),
	.rst_n(rst_n),
	.psel(psel),
	.penable(penable),
	.paddr(paddr),
	.pready(pready),
	.pslverr(pslverr),
	.switchMonitorCfg(switchMonitorCfg),
	.bootGroupCfg(bootGroupCfg),
	.sleepMode(sleepMode),
	.watchdogCfgEnable(watchdogCfgEnable),
	.softWatchdogEnable(softWatchdogEnable),
	.slowRcEnable(slowRcEnable),
	.sysClkGroup(sysClkGroup),
	.internalSystemReset(internalSystemReset),
	.firstQuarterPhase(firstQuarterPhase),
	.clockFailTrap(clockFailTrap)
);

// >>> tb_csm_clock_monitor.sv
// Purpose: self-checking bench for the clock monitor
// Assumes: 50 MHz ref_clk, 20 cycles per ms of power-up delay
// Notes: reads note expectations in a queue, a monitor compares
`timescale 1ns/1ps
module tb_csm_clock_monitor;
	// ****************************************
	// signals
	// ****************************************
	logic ref_clk, rst_n, psel, penable, pwrite, mclrN, priRun, hit, swdt;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb, primaryModeCfg, ev, code;
	logic [1:0] switchMonitorCfg, bootGroupCfg, powerUpDelayCfg, pllMultSel, sysClkGroup;
	logic [3:0] fastRcTrim;
	logic pready, pslverr, priClk, secClk, lock, priEn, secEn, fastEn, slowRcEnable;
	logic sysClkRun, internalSystemReset, firstQuarterPhase, clockFailTrap;
	logic [63:0] expQ[$];
	logic [63:0] note;
	logic [3:0] codes[3] = '{4'h0, 4'h7, 4'h8};
	logic [3:0] pllModes[3] = '{4'h5, 4'h6, 4'h7};
	int evBit[4] = '{4, 5, 8, 7};
	int mismatches = 0;
	int n_compared = 0;

	csm_clock_monitor #(.POWER_UP_UNIT_CYCLES(24'h000014)) dut_u (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.switchMonitorCfg(switchMonitorCfg), .bootGroupCfg(bootGroupCfg),
		.primaryModeCfg(primaryModeCfg), .powerUpDelayCfg(powerUpDelayCfg),
		.watchdogCfgEnable(1'b0), .softWatchdogEnable(swdt), .sleepMode(1'b0),
		.idleMode(1'b0), .wdtTimeout(ev[0]), .resetInstr(ev[1]), .trapLockup(ev[2]),
		.illegalOp(ev[3]), .masterClearPinN(mclrN), .brownOutDetect(1'b0),
		.primaryOscClk(priClk), .secondaryOscClk(secClk), .pllLockIn(lock),
		.primaryOscEnable(priEn), .secondaryOscEnable(secEn), .fastRcEnable(fastEn),
		.slowRcEnable(slowRcEnable), .pllMultSel(pllMultSel), .fastRcTrim(fastRcTrim),
		.sysClkGroup(sysClkGroup), .sysClkRun(sysClkRun),
		.internalSystemReset(internalSystemReset),
		.firstQuarterPhase(firstQuarterPhase), .clockFailTrap(clockFailTrap));

	csm_osc_model osc_u (.primaryOscEnable(priEn), .secondaryOscEnable(secEn),
		.priRun(priRun), .primaryOscClk(priClk), .secondaryOscClk(secClk),
		.pllLockIn(lock));

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// one idle edge first, so a release never meets a new setup
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
			@(posedge ref_clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, a, d, s);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		expQ.push_back({m, e});
		apb(1'b0, a, 32'h0, 4'h0);
	endtask

	task automatic unl(input logic hi);
		wr(12'h000, hi ? 32'h7800 : 32'h46, hi ? 4'h2 : 4'h1);
		wr(12'h000, hi ? 32'h9A00 : 32'h57, hi ? 4'h2 : 4'h1);
	endtask

	task automatic waitRun();
		@(negedge ref_clk);
		while (internalSystemReset !== 1'b0)
			@(negedge ref_clk);
	endtask

	task automatic doReset(input logic [1:0] m, input logic [1:0] b, input logic [3:0] p);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		switchMonitorCfg <= m;
		bootGroupCfg <= b;
		primaryModeCfg <= p;
		powerUpDelayCfg <= 2'($urandom_range(3));
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		waitRun();
		repeat (2) @(negedge ref_clk);
	endtask

	// ****************************************
	// read monitor
	// ****************************************
	always @(posedge ref_clk)
		if (psel && penable && !pwrite && pready)
		begin
			note = expQ.pop_front();
			check("read data", prdata & note[63:32], note[31:0]);
		end

	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	initial
	begin
		repeat (60000) @(posedge ref_clk);
		mismatches++;
		results();
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial
	begin
		void'($urandom(12));
		{rst_n, psel, penable, pwrite, paddr, pwdata, pstrb, ev, swdt} = '0;
		{mclrN, priRun} = 2'b11;
		doReset(2'h0, 2'h1, 4'h4);
		rd(12'h000, 32'h1100, 32'h330B);
		rd(12'h008, 32'h003, 32'h1FF);
		wr(12'h000, 32'h0300, 4'h2);
		rd(12'h000, 32'h1100, 32'h330B);
		wr(12'h000, 32'h7800, 4'h2);
		rd(12'h004, 32'h0, 32'h0);
		wr(12'h000, 32'h9A00, 4'h2);
		wr(12'h000, 32'h0300, 4'h2);
		rd(12'h000, 32'h1100, 32'h330B);
		unl(1'b1);
		wr(12'h000, 32'h0300, 4'h2);
		rd(12'h000, 32'h1300, 32'h330B);
		unl(1'b0);
		wr(12'h000, 32'h01, 4'h1);
		while (sysClkGroup !== 2'h3)
			@(negedge ref_clk);
		check("primary on", 32'(priEn), 32'h1);
		check("clock run", 32'(sysClkRun), 32'h1);
		rd(12'h000, 32'h3300, 32'h330B);
		priRun <= 1'b0;
		while (clockFailTrap !== 1'b1)
			@(negedge ref_clk);
		@(negedge ref_clk);
		check("fail group", 32'(sysClkGroup), 32'h1);
		check("fast rc on", 32'(fastEn), 32'h1);
		rd(12'h000, 32'h1308, 32'h330B);
		unl(1'b1);
		wr(12'h000, 32'h0000, 4'h2);
		unl(1'b0);
		wr(12'h000, 32'h01, 4'h1);
		unl(1'b0);
		wr(12'h000, 32'h00, 4'h1);
		rd(12'h000, 32'h1008, 32'h330B);
		unl(1'b0);
		wr(12'h000, 32'h02, 4'h1);
		repeat (2) @(negedge ref_clk);
		check("keep secondary", 32'(secEn), 32'h1);
		check("not selected", 32'(sysClkGroup), 32'h1);
		rd(12'h000, 32'h100A, 32'h330B);
		for (int i = 0; i < 4; i++)
		begin
			code = (i == 3) ? 4'($urandom()) : codes[i];
			wr(12'h004, {28'h0, code}, 4'hF);
			@(negedge ref_clk);
			check("trim", 32'(fastRcTrim), 32'(code));
			rd(12'h004, 32'(code), 32'hF);
		end
		rd(12'h010, 32'h0, 32'hFFFFFFFF);
		wr(12'h008, 32'h1FF, 4'hF);
		for (int k = 0; k < 4; k++)
		begin
			@(posedge ref_clk);
			ev <= 4'(1 << k);
			@(posedge ref_clk);
			ev <= 4'h0;
			repeat (2) @(posedge ref_clk);
			waitRun();
			rd(12'h008, 32'h1 << evBit[k], 32'h1FF);
			wr(12'h008, 32'h1FF, 4'hF);
		end
		@(posedge ref_clk);
		mclrN <= 1'b0;
		repeat (5) @(posedge ref_clk);
		mclrN <= 1'b1;
		hit = 1'b0;
		repeat (12)
		begin
			@(negedge ref_clk);
			hit = hit | internalSystemReset;
		end
		check("short pulse", 32'(hit), 32'h0);
		@(posedge ref_clk);
		mclrN <= 1'b0;
		repeat (30) @(posedge ref_clk);
		mclrN <= 1'b1;
		repeat (2) @(posedge ref_clk);
		waitRun();
		rd(12'h008, 32'h040, 32'h1FF);
		priRun <= 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			doReset(2'h2, 2'h3, pllModes[i]);
			check("mult", 32'(pllMultSel), 32'(i + 1));
			check("direct group", 32'(sysClkGroup), 32'h3);
			check("slow rc off", 32'(slowRcEnable), 32'h0);
		end
		@(posedge ref_clk);
		swdt <= 1'b1;
		repeat (2) @(negedge ref_clk);
		check("soft watchdog", 32'(slowRcEnable), 32'h1);
		@(posedge ref_clk);
		swdt <= 1'b0;
		doReset(2'h2, 2'h2, 4'h4);
		rd(12'h00C, 32'h345, 32'hFFFFFF7F);
		check("slow rc on", 32'(slowRcEnable), 32'h1);
		check("slow group", 32'(sysClkGroup), 32'h2);
		results();
	end
endmodule
